// ==== rtl/fp_status_pkg.sv ====
package fp_status_pkg;

  // raw detection causes delivered by each datapath source
  localparam int CAUSE_W       = 19;
  localparam int C_NAN_A       = 0;
  localparam int C_NAN_B       = 1;
  localparam int C_DEN_A       = 2;
  localparam int C_DEN_B       = 3;
  localparam int C_ZERO_INF    = 4;
  localparam int C_INF_OPP     = 5;
  localparam int C_SQRT_NEG    = 6;
  localparam int C_ZERO_DIV    = 7;
  localparam int C_RES_WRAP    = 8;
  localparam int C_INT_INVALID = 9;
  localparam int C_INEXACT     = 10;
  localparam int C_TOO_BIG     = 11;
  localparam int C_TOO_SMALL   = 12;
  localparam int C_ROUND_UP    = 13;
  localparam int C_RES_INF     = 14;
  localparam int C_RES_NEG     = 15;
  localparam int C_RES_ZERO    = 16;
  localparam int C_OPS_EQ      = 17;
  localparam int C_OPS_GT      = 18;

  // presented status word, also the order of the lockstep status pins
  localparam int STAT_W      = 18;
  localparam int S_EQ        = 0;
  localparam int S_GT        = 1;
  localparam int S_NAN_COMPARE_FLAG     = 2;
  localparam int S_CHAIN_OTHER_FAULT      = 3;
  localparam int S_SUBN_IN   = 4;
  localparam int S_SUBN_RES  = 5;
  localparam int S_ZDIV      = 6;
  localparam int S_FAULT     = 7;
  localparam int S_NOT_EXACT_FLAG      = 8;
  localparam int S_INF       = 9;
  localparam int S_BAD_OPERATION_FLAG      = 10;
  localparam int S_NEG       = 11;
  localparam int S_OVER      = 12;
  localparam int S_RCARRY    = 13;
  localparam int S_ORIGIN    = 14;
  localparam int S_PORT_B    = 15;
  localparam int S_PORT_A    = 16;
  localparam int S_UNDER     = 17;

  // maskable exceptions, one mask bit per source
  localparam int EXC_W       = 7;
  localparam int E_BAD_OPERATION_FLAG      = 0;
  localparam int E_ZDIV      = 1;
  localparam int E_OVER      = 2;
  localparam int E_UNDER     = 3;
  localparam int E_NOT_EXACT_FLAG      = 4;
  localparam int E_SUBN_RES  = 5;
  localparam int E_SUBN_IN   = 6;

  // status view codes
  localparam logic [1:0] VIEW_OR     = 2'h0;
  localparam logic [1:0] VIEW_MUL    = 2'h1;
  localparam logic [1:0] VIEW_ALU    = 2'h2;
  localparam logic [1:0] VIEW_NORMAL = 2'h3;

  // apb register map
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFF_MASK    = 8'h00;
  localparam logic [7:0]  OFF_STATUS  = 8'h04;
  localparam logic [7:0]  OFF_EXC     = 8'h08;
  localparam int          MASK_MUL_LO = 8;
  localparam logic [EXC_W-1:0] MASK_RST = 7'h00;

endpackage

// ==== rtl/lane_compare.sv ====
`timescale 1ns/1ns
`default_nettype none

// inequality of one lane, only while the compare is enabled
module lane_compare
#(
  parameter int W = 8
)
(
  // operands
  input  wire logic [W-1:0] own_val,
  input  wire logic [W-1:0] pin_val,
  // control
  input  wire logic         enable,
  // result
  output logic              differs
);

  // plain combinational compare; the caller registers the outcome
  assign differs = enable && (own_val != pin_val);

endmodule // lane_compare

`default_nettype wire

// ==== rtl/fp_status_exception_unit.sv ====
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module fp_status_exception_unit
  import fp_status_pkg::*;
#(
  parameter int Y_W = 32
)
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // operation context, aligned with the result stage
  input  wire logic              op_is_mul,
  input  wire logic              op_chained,
  input  wire logic              alu_compare,
  input  wire logic              flush_zero_mode,
  input  wire logic              output_reg_bypass,
  input  wire logic              chain_output_select,
  input  wire logic [1:0]        status_view_select,
  input  wire logic [CAUSE_W-1:0] alu_cause,
  input  wire logic [CAUSE_W-1:0] mul_cause,
  // output drive controls
  input  wire logic              y_bus_drive_n,
  input  wire logic              status_drive_n,
  input  wire logic              compare_drive_n,
  // lockstep inputs
  input  wire logic [Y_W-1:0]    y_internal,
  input  wire logic [Y_W-1:0]    y_pins_in,
  input  wire logic [STAT_W-1:0] status_pins_in,
  // comparison flags
  output logic                   a_equals_b_zero,
  output logic                   a_greater_than_b_flag,
  output logic                   nan_compare_flag,
  output logic                   cmp_pins_oe,
  // status and exception flags
  output logic                   chain_other_fault,
  output logic                   subnormal_mult_input,
  output logic                   subnormal_result_flag,
  output logic                   zero_divisor_flag,
  output logic                   fault_summary_out,
  output logic                   not_exact_flag,
  output logic                   unbounded_value_flag,
  output logic                   bad_operation_flag,
  output logic                   sign_minus_flag,
  output logic                   exceeds_max_flag,
  output logic                   rounding_carry_flag,
  output logic                   status_origin_flag,
  output logic                   port_b_bad_input,
  output logic                   port_a_bad_input,
  output logic                   below_min_flag,
  output logic                   stat_pins_oe,
  // lockstep result
  output logic                   lockstep_mismatch
);

  localparam int NBYTE = Y_W / 8;

  typedef struct packed {
    logic [EXC_W-1:0]  mask_alu;
    logic [EXC_W-1:0]  mask_mul;
    logic [STAT_W-1:0] stat;
    logic [EXC_W-1:0]  exc_alu;
    logic [EXC_W-1:0]  exc_mul;
    logic              mismatch;
    logic [31:0]       rdata;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  logic [STAT_W-1:0] alu_st;
  logic [STAT_W-1:0] mul_st;
  logic [STAT_W-1:0] sel_st;
  logic [STAT_W-1:0] pres_st;
  logic [EXC_W-1:0]  alu_exc;
  logic [EXC_W-1:0]  mul_exc;
  logic [EXC_W-1:0]  cur_exc_alu;
  logic [EXC_W-1:0]  cur_exc_mul;
  logic              alu_en;
  logic              mul_en;
  logic              sel_mul;
  logic              fault_comb;
  logic              all_off;
  logic [NBYTE-1:0]  byte_diff;
  logic              stat_diff;
  logic              wr_acc;
  logic              rd_setup;
  logic              mapped;

  // turn one source's raw causes into its status word
  function automatic logic [STAT_W-1:0] build_status(
    input logic [CAUSE_W-1:0] c,
    input logic               is_mul,
    input logic               compare,
    input logic               flush
  );
    logic [STAT_W-1:0] s;
    logic              tiny;
    s = '0;
    s[S_BAD_OPERATION_FLAG]     = c[C_NAN_A] | c[C_NAN_B] | c[C_ZERO_INF] |
                    c[C_INF_OPP] | c[C_SQRT_NEG];
    // zero divisor only from the multiplier
    s[S_ZDIV]     = is_mul & c[C_ZERO_DIV];
    s[S_SUBN_IN]  = is_mul & (c[C_DEN_A] | c[C_DEN_B]);
    // port of origin for NaN or denormal
    s[S_PORT_A]   = c[C_NAN_A] | c[C_DEN_A];
    s[S_PORT_B]   = c[C_NAN_B] | c[C_DEN_B];
    // wrapped, denormal or invalid integer result
    s[S_SUBN_RES] = c[C_RES_WRAP] | c[C_INT_INVALID];
    s[S_NOT_EXACT_FLAG]     = c[C_INEXACT];
    s[S_INF]      = c[C_RES_INF];
    s[S_NEG]      = c[C_RES_NEG];
    s[S_RCARRY]   = c[C_ROUND_UP];
    s[S_OVER]     = c[C_TOO_BIG];
    s[S_UNDER]    = c[C_INEXACT] & c[C_TOO_SMALL];
    // equality on compare, zero detect otherwise
    s[S_EQ]       = (compare & ~is_mul) ? c[C_OPS_EQ] : c[C_RES_ZERO];
    // greater than, only meaningful on compare
    s[S_GT]       = compare & ~is_mul & c[C_OPS_GT];
    s[S_NAN_COMPARE_FLAG]    = compare & ~is_mul & (c[C_NAN_A] | c[C_NAN_B]);
    // flush mode forces a tiny result to zero
    tiny = s[S_SUBN_RES] | s[S_UNDER];
    if (flush && tiny)
    begin
      s[S_NEG] = 1'b0;
      s[S_INF] = 1'b0;
      if (!(compare && !is_mul))
      begin
        s[S_EQ] = 1'b1;
      end
    end
    return s;
  endfunction

  // pick the maskable exception bits out of a status word
  function automatic logic [EXC_W-1:0] exc_of(
    input logic [STAT_W-1:0] s
  );
    logic [EXC_W-1:0] e;
    e             = '0;
    e[E_BAD_OPERATION_FLAG]     = s[S_BAD_OPERATION_FLAG];
    e[E_ZDIV]     = s[S_ZDIV];
    e[E_OVER]     = s[S_OVER];
    e[E_UNDER]    = s[S_UNDER];
    e[E_NOT_EXACT_FLAG]     = s[S_NOT_EXACT_FLAG];
    e[E_SUBN_RES] = s[S_SUBN_RES];
    e[E_SUBN_IN]  = s[S_SUBN_IN];
    return e;
  endfunction

  // an idle source reports nothing, both report when chained
  assign alu_en = ~op_is_mul | op_chained;
  assign mul_en = op_is_mul | op_chained;

  // per-source status words and their exceptions
  always_comb
  begin
    alu_st  = alu_en ? build_status(alu_cause, 1'b0, alu_compare,
                                    flush_zero_mode) : '0;
    mul_st  = mul_en ? build_status(mul_cause, 1'b1, 1'b0,
                                    flush_zero_mode) : '0;
    alu_exc = exc_of(alu_st);
    mul_exc = exc_of(mul_st);
  end

  // status selection; the OR view has no single origin, so the
  // chain select still names one for the origin flag
  always_comb
  begin
    sel_mul = op_chained ? chain_output_select : op_is_mul;
    sel_st  = alu_st;
    case (status_view_select)
      VIEW_OR:
      begin
        sel_st  = alu_st | mul_st;
        sel_mul = chain_output_select;
      end
      VIEW_MUL:
      begin
        sel_st  = mul_st;
        sel_mul = 1'b1;
      end
      VIEW_ALU:
      begin
        sel_st  = alu_st;
        sel_mul = 1'b0;
      end
      // normal selection follows the chain select when chained, otherwise op_is_mul
      default:
      begin
        sel_st = sel_mul ? mul_st : alu_st;
      end
    endcase
    sel_st[S_ORIGIN] = sel_mul;
    // the source not routed out raised an exception
    sel_st[S_CHAIN_OTHER_FAULT]   = op_chained &
                       (chain_output_select ? |alu_exc : |mul_exc);
    sel_st[S_FAULT]  = 1'b0;
  end

  // causes arrive on the result stage; the flowthrough path
  // bypasses the status register exactly when the Y register is off
  assign cur_exc_alu = output_reg_bypass ? alu_exc : st_ff.exc_alu;
  assign cur_exc_mul = output_reg_bypass ? mul_exc : st_ff.exc_mul;

  // masked exceptions merged; individual flags stay unmasked
  assign fault_comb = |(cur_exc_alu & ~st_ff.mask_alu) |
                      |(cur_exc_mul & ~st_ff.mask_mul);

  always_comb
  begin
    pres_st          = output_reg_bypass ? sel_st : st_ff.stat;
    pres_st[S_FAULT] = fault_comb;
  end

  // lockstep checking only while every drive is off
  assign all_off = y_bus_drive_n & status_drive_n & compare_drive_n;

  genvar gi;
  generate
    for (gi = 0; gi < NBYTE; gi++)
    begin : g_ybyte
      lane_compare #(.W(8)) u_ycmp
      (
        .own_val (y_internal[gi*8 +: 8]),
        .pin_val (y_pins_in[gi*8 +: 8]),
        .enable  (all_off),
        .differs (byte_diff[gi])
      );
    end
  endgenerate

  lane_compare #(.W(STAT_W)) u_scmp
  (
    .own_val (pres_st),
    .pin_val (status_pins_in),
    .enable  (all_off),
    .differs (stat_diff)
  );

  // apb decode; zero-wait slave, read data fetched in setup phase
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  always_comb
  begin
    if (paddr == OFF_MASK)
    begin
      mapped = 1'b1;
    end
    else if (paddr == OFF_STATUS)
    begin
      mapped = 1'b1;
    end
    else if (paddr == OFF_EXC)
    begin
      mapped = 1'b1;
    end
    else
    begin
      mapped = 1'b0;
    end
  end

  // next state
  always_comb
  begin
    nxt_st = st_ff;
    // status register captures only with output registers on
    if (!output_reg_bypass)
    begin
      nxt_st.stat    = sel_st;
      nxt_st.exc_alu = alu_exc;
      nxt_st.exc_mul = mul_exc;
    end
    // registered mismatch on any unequal byte or status bit
    nxt_st.mismatch = (|byte_diff) | stat_diff;
    // one mask bit per exception per source
    if (wr_acc && paddr == OFF_MASK)
    begin
      nxt_st.mask_alu = pwdata[EXC_W-1:0];
      nxt_st.mask_mul = pwdata[MASK_MUL_LO +: EXC_W];
    end
    if (rd_setup)
    begin
      nxt_st.rdata = '0;
      if (paddr == OFF_MASK)
      begin
        nxt_st.rdata[EXC_W-1:0]           = st_ff.mask_alu;
        nxt_st.rdata[MASK_MUL_LO +: EXC_W] = st_ff.mask_mul;
      end
      else if (paddr == OFF_STATUS)
      begin
        nxt_st.rdata[STAT_W-1:0] = pres_st;
        nxt_st.rdata[STAT_W]     = st_ff.mismatch;
      end
      else if (paddr == OFF_EXC)
      begin
        nxt_st.rdata[EXC_W-1:0]           = cur_exc_alu;
        nxt_st.rdata[MASK_MUL_LO +: EXC_W] = cur_exc_mul;
      end
    end
  end

  // reset clears status, pipeline copies and the mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff          <= '0;
      st_ff.mask_alu <= MASK_RST;
      st_ff.mask_mul <= MASK_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // apb outputs
  assign prdata  = st_ff.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // compare flags follow their own drive, the rest the status one
  assign cmp_pins_oe  = ~compare_drive_n;
  assign stat_pins_oe = ~status_drive_n;

  // flag outputs from the presented status word
  assign a_equals_b_zero       = pres_st[S_EQ];
  assign a_greater_than_b_flag = pres_st[S_GT];
  assign nan_compare_flag      = pres_st[S_NAN_COMPARE_FLAG];
  assign chain_other_fault     = pres_st[S_CHAIN_OTHER_FAULT];
  assign subnormal_mult_input  = pres_st[S_SUBN_IN];
  assign subnormal_result_flag = pres_st[S_SUBN_RES];
  assign zero_divisor_flag     = pres_st[S_ZDIV];
  assign fault_summary_out     = pres_st[S_FAULT];
  assign not_exact_flag        = pres_st[S_NOT_EXACT_FLAG];
  assign unbounded_value_flag  = pres_st[S_INF];
  assign bad_operation_flag    = pres_st[S_BAD_OPERATION_FLAG];
  assign sign_minus_flag       = pres_st[S_NEG];
  assign exceeds_max_flag      = pres_st[S_OVER];
  assign rounding_carry_flag   = pres_st[S_RCARRY];
  assign status_origin_flag    = pres_st[S_ORIGIN];
  assign port_b_bad_input      = pres_st[S_PORT_B];
  assign port_a_bad_input      = pres_st[S_PORT_A];
  assign below_min_flag        = pres_st[S_UNDER];
  assign lockstep_mismatch     = st_ff.mismatch;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_mismatch_idle: assert property (
    !all_off |=> !lockstep_mismatch)
    else $error("mismatch raised while a drive was on");

  a_mismatch_set: assert property (
    all_off && (y_internal != y_pins_in) |=> lockstep_mismatch)
    else $error("unequal Y bytes not flagged");

  a_status_capture: assert property (
    !output_reg_bypass ##1 !output_reg_bypass |->
      sign_minus_flag == $past(sel_st[S_NEG]))
    else $error("registered status did not follow its cause");

  a_oe_separate: assert property (
    $changed(status_drive_n) && $stable(compare_drive_n) |->
      $stable(cmp_pins_oe))
    else $error("compare drive moved with status drive");

  a_chain_fault: assert property (
    !output_reg_bypass && op_chained && chain_output_select &&
      (|alu_exc) |=> chain_other_fault)
    else $error("alu exception not reported as chain fault");

  a_idle_source: assert property (
    !output_reg_bypass && !op_chained && !op_is_mul |=>
      st_ff.exc_mul == '0)
    else $error("multiplier status leaked into alu instruction");

  a_view_mul: assert property (
    !output_reg_bypass && status_view_select == VIEW_MUL |=>
      status_origin_flag)
    else $error("multiplier view not marked as multiplier origin");

  a_fault_masked: assert property (
    fault_summary_out |->
      |((cur_exc_alu & ~st_ff.mask_alu) |
        (cur_exc_mul & ~st_ff.mask_mul)))
    else $error("fault summary high with all exceptions masked");

  a_mask_write: assert property (
    wr_acc && paddr == OFF_MASK |=>
      st_ff.mask_alu == $past(pwdata[EXC_W-1:0]))
    else $error("mask write not stored");

endmodule // fp_status_exception_unit

`default_nettype wire

// ==== bench/lockstep_peer.sv ====
`timescale 1ns/1ns
`default_nettype none

// peer in lockstep: repeats our values, or a corrupted copy on command
module lockstep_peer
  import fp_status_pkg::*;
(
  // own values and enables
  input  wire logic [31:0]       own_y,
  input  wire logic [STAT_W-1:0] own_stat,
  input  wire logic              y_drive_n,
  input  wire logic              stat_oe,
  input  wire logic              cmp_oe,
  // injected faults
  input  wire logic [31:0]       y_flip,
  input  wire logic [STAT_W-1:0] s_flip,
  // resolved pin levels
  output logic [31:0]            y_pins,
  output logic [STAT_W-1:0]      stat_pins
);
  logic [STAT_W-1:0] cmp_bits;
  logic [STAT_W-1:0] ours;

  // compare pins follow their own enable, the rest the status enable
  assign cmp_bits = STAT_W'(7);
  assign ours = (cmp_oe ? cmp_bits : '0) | (stat_oe ? ~cmp_bits : '0);
  assign y_pins = own_y ^ (y_drive_n ? y_flip : 32'h0);
  assign stat_pins = own_stat ^ (s_flip & ~ours);
endmodule // lockstep_peer

`default_nettype wire

// ==== bench/fp_status_exception_unit_tb.sv ====
`timescale 1ns/1ns
`default_nettype none

module fp_status_exception_unit_tb;
  import fp_status_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, y_internal, y_pins_in, y_flip;
  logic op_is_mul, op_chained, alu_compare, flush_zero_mode;
  logic output_reg_bypass, chain_output_select;
  logic [1:0] status_view_select;
  logic [CAUSE_W-1:0] alu_cause, mul_cause;
  logic y_bus_drive_n, status_drive_n, compare_drive_n;
  logic [STAT_W-1:0] status_pins_in, s_flip;
  wire logic [STAT_W-1:0] obs;
  wire logic cmp_pins_oe, stat_pins_oe, lockstep_mismatch;
  logic [14:0] msk;
  int mismatches, samples_checked, cyc;
  int seed = 17908;

  fp_status_exception_unit u_fp_status_exception_unit (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .op_is_mul, .op_chained, .alu_compare,
    .flush_zero_mode, .output_reg_bypass, .chain_output_select,
    .status_view_select, .alu_cause, .mul_cause, .y_bus_drive_n,
    .status_drive_n, .compare_drive_n, .y_internal, .y_pins_in,
    .status_pins_in, .a_equals_b_zero(obs[S_EQ]),
    .a_greater_than_b_flag(obs[S_GT]), .nan_compare_flag(obs[S_NAN_COMPARE_FLAG]),
    .cmp_pins_oe, .chain_other_fault(obs[S_CHAIN_OTHER_FAULT]),
    .subnormal_mult_input(obs[S_SUBN_IN]),
    .subnormal_result_flag(obs[S_SUBN_RES]),
    .zero_divisor_flag(obs[S_ZDIV]), .fault_summary_out(obs[S_FAULT]),
    .not_exact_flag(obs[S_NOT_EXACT_FLAG]), .unbounded_value_flag(obs[S_INF]),
    .bad_operation_flag(obs[S_BAD_OPERATION_FLAG]), .sign_minus_flag(obs[S_NEG]),
    .exceeds_max_flag(obs[S_OVER]), .rounding_carry_flag(obs[S_RCARRY]),
    .status_origin_flag(obs[S_ORIGIN]), .port_b_bad_input(obs[S_PORT_B]),
    .port_a_bad_input(obs[S_PORT_A]), .below_min_flag(obs[S_UNDER]),
    .stat_pins_oe, .lockstep_mismatch);

  lockstep_peer u_lockstep_peer (
    .own_y(y_internal), .own_stat(obs), .y_drive_n(y_bus_drive_n),
    .stat_oe(stat_pins_oe), .cmp_oe(cmp_pins_oe), .y_flip, .s_flip,
    .y_pins(y_pins_in), .stat_pins(status_pins_in));

  // clock, 100 ns period
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // one source's flags from its raw causes
  function automatic logic [STAT_W-1:0] src_stat(
    input logic [CAUSE_W-1:0] c, input logic mu, input logic cp,
    input logic fl);
    logic [STAT_W-1:0] s;
    s = '0;
    s[S_BAD_OPERATION_FLAG] = |{c[C_NAN_A], c[C_NAN_B], c[C_ZERO_INF], c[C_INF_OPP],
                  c[C_SQRT_NEG]};
    s[S_PORT_A] = c[C_NAN_A] | c[C_DEN_A];
    s[S_PORT_B] = c[C_NAN_B] | c[C_DEN_B];
    s[S_SUBN_IN] = mu & (c[C_DEN_A] | c[C_DEN_B]);
    s[S_SUBN_RES] = c[C_RES_WRAP] | c[C_INT_INVALID];
    s[S_ZDIV] = mu & c[C_ZERO_DIV];
    s[S_NOT_EXACT_FLAG] = c[C_INEXACT];
    s[S_OVER] = c[C_TOO_BIG];
    s[S_UNDER] = c[C_TOO_SMALL] & c[C_INEXACT];
    s[S_RCARRY] = c[C_ROUND_UP];
    s[S_INF] = c[C_RES_INF];
    s[S_NEG] = c[C_RES_NEG];
    s[S_EQ] = cp ? c[C_OPS_EQ] : c[C_RES_ZERO];
    s[S_GT] = cp & c[C_OPS_GT];
    s[S_NAN_COMPARE_FLAG] = cp & (c[C_NAN_A] | c[C_NAN_B]);
    // flushed tiny result reads as zero; a compare keeps equality
    if (fl && (s[S_UNDER] || s[S_SUBN_RES]))
    begin
      s[S_EQ] = s[S_EQ] | ~cp;
      s[S_NEG] = 1'b0;
      s[S_INF] = 1'b0;
    end
    return s;
  endfunction

  function automatic logic [EXC_W-1:0] exc(input logic [STAT_W-1:0] s);
    return {s[S_SUBN_IN], s[S_SUBN_RES], s[S_NOT_EXACT_FLAG], s[S_UNDER], s[S_OVER],
            s[S_ZDIV], s[S_BAD_OPERATION_FLAG]};
  endfunction

  // presented status word
  function automatic logic [STAT_W-1:0] present(
    input logic [CAUSE_W-1:0] a, input logic [CAUSE_W-1:0] m,
    input logic [5:0] k, input logic [1:0] vw);
    logic [STAT_W-1:0] sa, sm, p;
    logic usem;
    sa = src_stat(a, 1'b0, k[2], k[3]);
    sm = src_stat(m, 1'b1, 1'b0, k[3]);
    if (!k[1] && k[0]) sa = '0;
    if (!k[1] && !k[0]) sm = '0;
    usem = k[1] ? k[4] : k[0];
    case (vw)
      VIEW_OR:  p = sa | sm;
      VIEW_MUL: p = sm;
      VIEW_ALU: p = sa;
      default:  p = usem ? sm : sa;
    endcase
    p[S_ORIGIN] = vw == VIEW_OR ? k[4] : vw == VIEW_MUL ? 1'b1 :
                  vw == VIEW_ALU ? 1'b0 : usem;
    p[S_CHAIN_OTHER_FAULT] = k[1] & (k[4] ? |exc(sa) : |exc(sm));
    p[S_FAULT] = |(exc(sa) & ~msk[6:0]) | |(exc(sm) & ~msk[14:8]);
    return p;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] ad,
    input logic [31:0] wd, output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // reset held 20 cycles; outputs looked at just before release
  task automatic do_reset();
    logic [31:0] rd;
    logic er;
    presetn <= 1'b0;
    // quiet stimulus so the release edge sees no stale cause or fault
    {alu_cause, mul_cause, y_flip, s_flip} <= '0;
    {op_is_mul, op_chained, alu_compare, flush_zero_mode} <= 4'h0;
    status_view_select <= VIEW_NORMAL;
    repeat (19) @(posedge pclk);
    @(negedge pclk);
    chk(obs, 0);
    chk(lockstep_mismatch, 0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_MASK, 0, rd, er);
    chk(rd, 32'(MASK_RST));
  endtask

  // random results, drive enables and peer faults, n cycles
  task automatic run_block(input int n, input logic byp,
    output logic [STAT_W-1:0] cur, output logic cur_mm);
    logic [STAT_W-1:0] prev, s_f;
    logic [CAUSE_W-1:0] a, m;
    logic [31:0] r, y_f;
    logic [5:0] k;
    logic [1:0] vw;
    logic [2:0] dn;
    logic prev_mm, ok;
    ok = 1'b0;
    output_reg_bypass <= byp;
    for (int i = 0; i < n; i++)
    begin
      @(posedge pclk);
      r = $random(seed);
      a = CAUSE_W'($random(seed) & $random(seed) & $random(seed));
      m = CAUSE_W'($random(seed) & $random(seed) & $random(seed));
      a[C_INEXACT] = a[C_INEXACT] | a[C_TOO_SMALL];
      m[C_INEXACT] = m[C_INEXACT] | m[C_TOO_SMALL];
      k = {1'b0, r[4:3], r[2] & ~r[0] & ~r[1], r[1:0]};
      vw = k[1] ? r[6:5] : VIEW_NORMAL;
      dn = r[9:7] | r[12:10];
      y_f = 32'h0;
      s_f = '0;
      if (r[14:13] == 2'h1) y_f[r[19:15]] = 1'b1;
      if (r[14:13] == 2'h2) s_f[r[24:20] % STAT_W] = 1'b1;
      cur = present(a, m, k, vw);
      cur_mm = (&dn) & ((|y_f) | (|s_f));
      alu_cause <= a;
      mul_cause <= m;
      {flush_zero_mode, alu_compare, op_chained, op_is_mul} <= k[3:0];
      chain_output_select <= k[4];
      status_view_select <= vw;
      {y_bus_drive_n, status_drive_n, compare_drive_n} <= dn;
      y_internal <= $random(seed);
      y_flip <= y_f;
      s_flip <= s_f;
      @(negedge pclk);
      if (byp)
        chk(obs, cur);
      chk({cmp_pins_oe, stat_pins_oe}, {~dn[0], ~dn[1]});
      if (ok && !byp)
        chk(obs, prev);
      if (ok)
        chk(lockstep_mismatch, prev_mm);
      prev = cur;
      prev_mm = cur_mm;
      ok = 1'b1;
    end
  endtask

  // timeout guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      $display("BAD t=%0t timeout", $time);
      print_verdict();
    end
  end

  initial
  begin
    logic [31:0] rd, wd;
    logic er, mm;
    logic [STAT_W-1:0] cur;
    {psel, penable, pwrite, paddr, pwdata, msk} = '0;
    {op_is_mul, op_chained, alu_compare, flush_zero_mode} = '0;
    {output_reg_bypass, chain_output_select, status_view_select} = '0;
    {alu_cause, mul_cause, y_internal, y_flip, s_flip} = '0;
    {y_bus_drive_n, status_drive_n, compare_drive_n} = 3'h7;
    presetn = 1'b0;
    do_reset();
    apb(1'b0, 8'h0C, 0, rd, er);
    chk(er, 1);
    chk(rd, 0);
    $display("reset and decode test done");
    for (int b = 0; b < 4; b++)
    begin
      wd = $random(seed) & 32'h7F7F;
      apb(1'b1, OFF_MASK, wd, rd, er);
      apb(1'b0, OFF_MASK, 0, rd, er);
      chk(rd, wd);
      msk = wd[14:0];
      run_block(60, 1'b0, cur, mm);
      apb(1'b0, OFF_STATUS, 0, rd, er);
      chk(rd[18:0], {mm, cur});
      $display("random block %0d done", b);
    end
    do_reset();
    msk = '0;
    run_block(40, 1'b1, cur, mm);
    $display("flowthrough block done");
    print_verdict();
  end
endmodule // fp_status_exception_unit_tb

`default_nettype wire
